// file: hw/iag_core.sv
`timescale 1ns/1ps
`default_nettype none
module iag_core (
    // Clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Core access port
    input wire logic acc_valid,
    output logic acc_ready,
    input wire iag_pkg::iag_req_t acc_req,
    input wire logic [3:0] bank_select_register,
    output logic acc_done,
    output logic [7:0] acc_rdata,
    // Data memory port
    output logic [11:0] mem_addr,
    output logic mem_re,
    output logic mem_we,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata
);
    // Pointer storage and control
    logic [11:0] ptr_q [0:2];
    logic xset_q;
    // Access pipeline
    logic ph1_q;
    logic [11:0] tgt_q;
    logic mem_re_q;
    logic mem_we_q;
    logic [7:0] mem_wdata_q;
    logic use_mem_q;
    logic [7:0] local_q;
    logic null_q;
    logic acc_done_q;
    logic [7:0] acc_rdata_q;
    // Bus pipeline
    logic ahb_wr_q;
    logic [7:0] ahb_addr_q;
    logic [31:0] hrdata_q;
    // Combinational address path
    logic take;
    logic [11:0] eff;
    logic indexed;
    iag_pkg::iag_dec_t effd;
    iag_pkg::iag_dec_t tgtd;
    logic [1:0] vp;
    logic [11:0] old;
    logic [11:0] tgt;
    logic null_acc;
    logic [7:0] ptr_rd;
    logic [2:0] ahb_ptr_wr;
    logic [2:0] own_wr;

    // Handshake outputs
    assign hreadyout = ce;
    assign hresp = iag_pkg::HRESP_OKAY;
    // Ready falls with the clock enable, so a frozen cycle never looks taken
    assign acc_ready = ce & ~ph1_q;
    assign take = acc_valid & acc_ready;
    // Data outputs from flops
    assign hrdata = hrdata_q;
    assign acc_done = acc_done_q;
    assign acc_rdata = acc_rdata_q;
    assign mem_addr = tgt_q;
    assign mem_re = mem_re_q;
    assign mem_we = mem_we_q;
    assign mem_wdata = mem_wdata_q;

    // Effective file address from the instruction field
    always_comb begin
        indexed = 1'b0;
        if (acc_req.abit) begin
            eff = {bank_select_register, acc_req.faddr};
        end else if (xset_q && acc_req.faddr <= iag_pkg::INDEX_MAX) begin
            indexed = 1'b1;
            eff = ptr_q[2] + {4'h0, acc_req.faddr};
        end else if (acc_req.faddr >= iag_pkg::ACCESS_SPLIT) begin
            eff = {iag_pkg::UPPER_BANK, acc_req.faddr};
        end else begin
            eff = {iag_pkg::LOWER_BANK, acc_req.faddr};
        end
    end

    // Indirect target through a virtual operand
    always_comb begin
        effd = iag_pkg::iag_decode(eff);
        vp = effd.pair;
        old = ptr_q[vp];
        tgt = eff;
        if (effd.virt) begin
            case (effd.sub)
                iag_pkg::OP_W_OFFSET: tgt = old + iag_pkg::iag_sext(acc_req.wval);
                iag_pkg::OP_PRE_INC: tgt = old + 12'h001;
                default: tgt = old;
            endcase
        end
        tgtd = iag_pkg::iag_decode(tgt);
        // Pointer aimed at a virtual operand gives a null access
        null_acc = effd.virt & tgtd.virt;
        // Local read of a pointer byte, unused nibble reads zero
        if (tgtd.ptr_lo) begin
            ptr_rd = ptr_q[tgtd.pair][7:0];
        end else begin
            ptr_rd = {4'h0, ptr_q[tgtd.pair][11:8]};
        end
    end

    // Which pairs are written this cycle
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            ahb_ptr_wr[p] = ce & ahb_wr_q & (ahb_addr_q == 8'(4 * p));
            own_wr[p] = take & acc_req.write & ~tgtd.virt & (tgtd.ptr_lo | tgtd.ptr_hi)
                & (tgtd.pair == 2'(p));
        end
    end

    // Pointer pairs: bus write, core write, then automatic step
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int p = 0; p < 3; p++) begin
                ptr_q[p] <= iag_pkg::PTR_RST;
            end
        end else begin
            for (int p = 0; p < 3; p++) begin
                if (ahb_ptr_wr[p]) begin
                    // Software write wins
                    ptr_q[p] <= hwdata[11:0];
                end else if (own_wr[p]) begin
                    // Stored as written, no step afterwards
                    if (tgtd.ptr_lo) begin
                        ptr_q[p] <= {ptr_q[p][11:8], acc_req.wdata};
                    end else begin
                        ptr_q[p] <= {acc_req.wdata[3:0], ptr_q[p][7:0]};
                    end
                end else if (take && effd.virt && vp == 2'(p)) begin
                    // Whole-pair step, no flag side effects
                    case (effd.sub)
                        iag_pkg::OP_POST_INC: ptr_q[p] <= ptr_q[p] + 12'h001;
                        iag_pkg::OP_PRE_INC: ptr_q[p] <= ptr_q[p] + 12'h001;
                        iag_pkg::OP_POST_DEC: ptr_q[p] <= ptr_q[p] - 12'h001;
                        default: ptr_q[p] <= ptr_q[p];
                    endcase
                end
            end
        end
    end

    // Request stage: latch target and drive memory strobes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph1_q <= 1'b0;
            tgt_q <= 12'h000;
            mem_re_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_wdata_q <= 8'h00;
            use_mem_q <= 1'b0;
            local_q <= 8'h00;
            null_q <= 1'b0;
        end else if (ce) begin
            ph1_q <= take;
            mem_re_q <= 1'b0;
            mem_we_q <= 1'b0;
            if (take) begin
                tgt_q <= tgt;
                null_q <= null_acc;
                mem_wdata_q <= acc_req.wdata;
                if (null_acc) begin
                    // No memory cycle, read gives zero
                    use_mem_q <= 1'b0;
                    local_q <= 8'h00;
                end else if (tgtd.ptr_lo || tgtd.ptr_hi) begin
                    // Pointer bytes live here
                    use_mem_q <= 1'b0;
                    local_q <= ptr_rd;
                end else begin
                    // Any other location or register
                    use_mem_q <= 1'b1;
                    local_q <= 8'h00;
                    mem_re_q <= ~acc_req.write;
                    mem_we_q <= acc_req.write;
                end
            end
        end
    end

    // Answer stage: return read data one cycle later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_done_q <= 1'b0;
            acc_rdata_q <= 8'h00;
        end else if (ce) begin
            acc_done_q <= ph1_q;
            if (ph1_q) begin
                acc_rdata_q <= use_mem_q ? mem_rdata : local_q;
            end
        end
    end

    // Extended-set control bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xset_q <= iag_pkg::CTRL_XSET_RST;
        end else if (ce && ahb_wr_q && ahb_addr_q == iag_pkg::REG_CTRL) begin
            xset_q <= hwdata[iag_pkg::CTRL_XSET_BIT];
        end
    end

    // Bus address phase and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ahb_wr_q <= 1'b0;
            ahb_addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end else if (ce) begin
            ahb_wr_q <= 1'b0;
            if (hsel && hready && htrans == iag_pkg::HTRANS_NONSEQ) begin
                ahb_wr_q <= hwrite;
                ahb_addr_q <= haddr[7:0];
                hrdata_q <= 32'h0000_0000;
                if (!hwrite && haddr[31:8] == 24'h00_0000) begin
                    // Unmapped offsets read zero
                    case (haddr[7:0])
                        iag_pkg::REG_PTR0: hrdata_q <= {20'h0_0000, ptr_q[0]};
                        iag_pkg::REG_PTR1: hrdata_q <= {20'h0_0000, ptr_q[1]};
                        iag_pkg::REG_PTR2: hrdata_q <= {20'h0_0000, ptr_q[2]};
                        iag_pkg::REG_CTRL: hrdata_q <= {31'h0000_0000, xset_q};
                        iag_pkg::REG_STAT: hrdata_q <= {15'h0000, null_q, 4'h0, tgt_q};
                        default: hrdata_q <= 32'h0000_0000;
                    endcase
                end
            end else if (hready) begin
                ahb_addr_q <= 8'hff;
            end
        end
    end

    // Checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic quiet;
    assign quiet = ~(|ahb_ptr_wr) & ~(|own_wr);

    post_inc_step_a: assert property (
        take && effd.virt && effd.sub == iag_pkg::OP_POST_INC && quiet
        |=> tgt_q == $past(old) && ptr_q[$past(vp)] == $past(old) + 12'h001)
        else $error("post-increment step wrong");
    post_dec_step_a: assert property (
        take && effd.virt && effd.sub == iag_pkg::OP_POST_DEC && quiet
        |=> tgt_q == $past(old) && ptr_q[$past(vp)] == $past(old) - 12'h001)
        else $error("post-decrement step wrong");
    pre_inc_addr_a: assert property (
        take && effd.virt && effd.sub == iag_pkg::OP_PRE_INC && quiet
        |=> tgt_q == $past(old) + 12'h001 && tgt_q == ptr_q[$past(vp)])
        else $error("pre-increment address wrong");
    w_offset_keep_a: assert property (
        take && effd.virt && effd.sub == iag_pkg::OP_W_OFFSET && quiet
        |=> tgt_q == $past(old) + iag_pkg::iag_sext($past(acc_req.wval))
            && ptr_q[$past(vp)] == $past(old))
        else $error("offset access wrong");
    null_read_zero_a: assert property (
        take && !acc_req.write && null_acc ##1 ce
        |=> acc_done && acc_rdata == 8'h00)
        else $error("virtual read not zero");
    null_write_nop_a: assert property (
        take && acc_req.write && null_acc |=> !mem_we && !mem_re ##1 !mem_we)
        else $error("virtual write reached memory");
    bank_join_a: assert property (
        take && acc_req.abit && !effd.virt
        |=> tgt_q == {$past(bank_select_register), $past(acc_req.faddr)})
        else $error("banked address wrong");
    upper_access_a: assert property (
        take && !acc_req.abit && acc_req.faddr >= iag_pkg::ACCESS_SPLIT && !effd.virt
        |=> tgt_q[11:8] == iag_pkg::UPPER_BANK)
        else $error("upper access region wrong");
    indexed_sum_a: assert property (
        take && indexed && !effd.virt
        |=> tgt_q == $past(ptr_q[2]) + {4'h0, $past(acc_req.faddr)})
        else $error("indexed address wrong");
    // Plain operand, pointer bytes, memory strobes and lower access region
    plain_keep_a: assert property (
        take && effd.virt && effd.sub == iag_pkg::OP_PLAIN && quiet
        |=> tgt_q == $past(old) && ptr_q[$past(vp)] == $past(old))
        else $error("plain access moved pointer");
    own_write_lo_a: assert property (
        take && acc_req.write && tgtd.ptr_lo && !(|ahb_ptr_wr)
        |=> ptr_q[$past(tgtd.pair)][7:0] == $past(acc_req.wdata))
        else $error("pointer low byte write wrong");
    own_write_hi_a: assert property (
        take && acc_req.write && tgtd.ptr_hi && !(|ahb_ptr_wr)
        |=> ptr_q[$past(tgtd.pair)][11:8] == $past(acc_req.wdata[3:0]))
        else $error("pointer high byte write wrong");
    ptr_byte_local_a: assert property (
        take && (tgtd.ptr_lo || tgtd.ptr_hi) |=> !mem_re && !mem_we)
        else $error("pointer byte reached memory");
    ptr_high_read_a: assert property (
        take && !acc_req.write && tgtd.ptr_hi ##1 ce
        |=> acc_done && acc_rdata[7:4] == 4'h0)
        else $error("unused pointer bits read back");
    mem_strobe_a: assert property (
        take && !null_acc && !tgtd.ptr_lo && !tgtd.ptr_hi
        |=> mem_we == $past(acc_req.write) && mem_re == !$past(acc_req.write))
        else $error("memory strobe wrong");
    lower_access_a: assert property (
        take && !acc_req.abit && acc_req.faddr <= iag_pkg::INDEX_MAX && !xset_q
        |=> tgt_q == {iag_pkg::LOWER_BANK, $past(acc_req.faddr)})
        else $error("lower access region wrong");
    // Handshake timing and clock enable
    ready_drop_a: assert property (
        take |=> !acc_ready)
        else $error("request taken twice");
    done_time_a: assert property (
        take ##1 ce |=> acc_done)
        else $error("access answer late");
    ce_freeze_a: assert property (
        !ce |=> $stable(tgt_q) && $stable(acc_done) && $stable(xset_q)
            && $stable(ptr_q[0]) && $stable(ptr_q[1]) && $stable(ptr_q[2]))
        else $error("state moved while disabled");

    // Main scenarios reached
    post_inc_c: cover property (take && effd.virt && effd.sub == iag_pkg::OP_POST_INC);
    ce_stall_c: cover property (!ce && acc_valid);
    indexed_c: cover property (take && indexed);
    null_read_c: cover property (take && !acc_req.write && null_acc);
    own_write_c: cover property (take && |own_wr && effd.virt);
endmodule
`default_nettype wire

// file: hw/iag_pkg.sv
// How it works
// - Three 12-bit pointer pairs, high nibble unused
// - Plain operand accesses pointer target, pointer unchanged
// - Pointer addresses use twelve bits, ignore bank
// - Post-decrement uses old pointer, then subtracts one
// - Post-increment uses old pointer, then adds one
// - Pre-increment adds one, then uses new pointer
// - Offset operand addresses pointer plus signed W
// - Offset operand changes neither W nor pointer
// - Updates act on whole pair with carry
// - Pointer updates never touch arithmetic status flags
// - Indirect read of virtual operand returns zero
// - Indirect write to virtual operand does nothing
// - Write to own pointer skips automatic update
// - Pointer bytes are directly readable, writable registers
// - Indirect access reaches all other registers normally
// - Extended mode leaves pairs 0, 1 unchanged
// - Indexed mode only when access clear, address<=5Fh
// - Indexed target is pair 2 plus literal
// - Extended mode keeps memory size and linearity
// - Access clear, address>=60h selects upper region
// - Access set joins bank select with address
package iag_pkg;
    // Widths
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;
    // Virtual operand window in the special function register space
    localparam logic [11:0] VIRT_LO = 12'hfd8;
    localparam logic [11:0] VIRT_HI = 12'hfef;
    // Sub-slot codes inside one pointer group
    localparam logic [2:0] SUB_PTR_LO = 3'h1;
    localparam logic [2:0] SUB_PTR_HI = 3'h2;
    localparam logic [2:0] OP_W_OFFSET = 3'h3;
    localparam logic [2:0] OP_PRE_INC = 3'h4;
    localparam logic [2:0] OP_POST_DEC = 3'h5;
    localparam logic [2:0] OP_POST_INC = 3'h6;
    localparam logic [2:0] OP_PLAIN = 3'h7;
    // Access bank split points
    localparam logic [7:0] INDEX_MAX = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] UPPER_BANK = 4'hf;
    localparam logic [3:0] LOWER_BANK = 4'h0;
    // Reset values
    localparam logic [11:0] PTR_RST = 12'h000;
    localparam logic CTRL_XSET_RST = 1'b0;
    // Register offsets on the bus
    localparam logic [7:0] REG_PTR0 = 8'h00;
    localparam logic [7:0] REG_PTR1 = 8'h04;
    localparam logic [7:0] REG_PTR2 = 8'h08;
    localparam logic [7:0] REG_CTRL = 8'h0c;
    localparam logic [7:0] REG_STAT = 8'h10;
    // Field positions
    localparam int unsigned CTRL_XSET_BIT = 0;
    localparam int unsigned STAT_NULL_BIT = 16;
    // Bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // One core access request
    typedef struct packed {
        logic write;
        logic abit;
        logic [7:0] faddr;
        logic [7:0] wval;
        logic [7:0] wdata;
    } iag_req_t;

    // Classification of one 12-bit data address
    typedef struct packed {
        logic virt;
        logic ptr_lo;
        logic ptr_hi;
        logic [1:0] pair;
        logic [2:0] sub;
    } iag_dec_t;

    // Classify an address against the pointer groups
    function automatic iag_dec_t iag_decode(input logic [11:0] a);
        iag_dec_t d;
        d = '0;
        if (a >= VIRT_LO && a <= VIRT_HI) begin
            case (a[4:3])
                2'h3: d.pair = 2'h2;
                2'h0: d.pair = 2'h1;
                default: d.pair = 2'h0;
            endcase
            d.sub = a[2:0];
            d.virt = (a[2:0] >= OP_W_OFFSET);
            d.ptr_lo = (a[2:0] == SUB_PTR_LO);
            d.ptr_hi = (a[2:0] == SUB_PTR_HI);
        end
        return d;
    endfunction

    // Sign-extend W to pointer width
    function automatic logic [11:0] iag_sext(input logic [7:0] w);
        return {{4{w[7]}}, w};
    endfunction
endpackage

// file: sim/iag_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module iag_core_tb_top;
    logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp, xset;
    logic acc_valid, acc_ready, acc_done, mem_re, mem_we;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] bank_sel;
    logic [7:0] acc_rdata, mem_wdata, mem_rdata;
    logic [11:0] mem_addr;
    logic [11:0] ptr [3]; // Expected pointer pairs
    logic [7:0] shadow [4096]; // Expected memory bytes
    iag_pkg::iag_req_t acc_req;
    int err_count = 0, checks_done = 0, n_re = 0, n_we = 0;
    // One slave, so its ready is the bus ready
    assign hready = hreadyout;
    iag_core iag_core_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .acc_valid(acc_valid),
        .acc_ready(acc_ready), .acc_req(acc_req), .bank_select_register(bank_sel),
        .acc_done(acc_done), .acc_rdata(acc_rdata), .mem_addr(mem_addr), .mem_re(mem_re),
        .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    iag_mem_model iag_mem_model_i (.hclk(hclk), .mem_addr(mem_addr), .mem_re(mem_re),
        .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    // Clock
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Memory strobe counters
    always @(posedge hclk) begin
        n_re <= n_re + int'(mem_re);
        n_we <= n_we + int'(mem_we);
    end
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_word({24'h0, got}, {24'h0, exp});
    endtask
    task automatic cmp_addr(input logic [11:0] got, input logic [11:0] exp);
        cmp_word({20'h0, got}, {20'h0, exp});
    endtask
    task automatic print_verdict();
        if (err_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Bounded wait for a rising edge that samples hready, acc_ready or acc_done high
    task automatic wait_hi(input int sel);
        int n;
        n = 0;
        @(posedge hclk);
        while (((sel == 0) ? hready : (sel == 1) ? acc_ready : acc_done) !== 1'b1) begin
            n++;
            if (n > 200) begin
                err_count++;
                print_verdict();
            end
            @(posedge hclk);
        end
    endtask
    // One single-word bus transfer, read data lands in rd
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        haddr <= a;
        hwrite <= wr;
        htrans <= iag_pkg::HTRANS_NONSEQ;
        wait_hi(0);
        htrans <= 2'h0;
        hwdata <= d;
        wait_hi(0);
        rd = hrdata;
        cmp_byte({7'h0, hresp}, 8'h0);
    endtask
    // One core request, returns once the done pulse is seen
    task automatic core(input logic wr, input logic ab, input logic [7:0] f,
                        input logic [7:0] w, input logic [7:0] d, input logic [3:0] b);
        @(posedge hclk);
        acc_valid <= 1'b1;
        acc_req <= {wr, ab, f, w, d};
        bank_sel <= b;
        // Random one-cycle freeze while the request stands
        if (1'($urandom)) begin
            ce <= 1'b0;
            @(posedge hclk);
            ce <= 1'b1;
        end
        wait_hi(1);
        acc_valid <= 1'b0;
        wait_hi(2);
    endtask
    task automatic set_ptr(input int q, input logic [11:0] v);
        ptr[q] = v;
        bus(1'b1, 32'(q * 4), {20'hfffff, v});
    endtask
    task automatic chk_ptrs();
        for (int q = 0; q < 3; q++) begin
            bus(1'b0, 32'(q * 4), 32'h0);
            cmp_word(rd, {20'h0, ptr[q]});
        end
    endtask
    // Effective address of the file-address field
    function automatic logic [11:0] eff(input logic ab, input logic [7:0] f,
                                        input logic [3:0] b);
        if (ab) return {b, f};
        if (f >= 8'h60) return {4'hf, f};
        if (xset) return ptr[2] + {4'h0, f};
        return {4'h0, f};
    endfunction
    // One access to a memory target, with full checking
    task automatic step(input logic wr, input logic ab, input logic [7:0] f,
                        input logic [3:0] b);
        logic [11:0] e, t;
        logic [7:0] w, d;
        int p, re0, we0;
        w = 8'($urandom);
        d = 8'($urandom);
        e = eff(ab, f, b);
        t = e;
        p = (e[4:3] == 2'h3) ? 2 : (e[4:3] == 2'h0) ? 1 : 0;
        if (e >= 12'hfd8 && e <= 12'hfef && e[2:0] >= 3'h3) begin
            t = (e[2:0] == 3'h3) ? ptr[p] + {{4{w[7]}}, w} : ptr[p] + 12'(e[2:0] == 3'h4);
        end
        if (t >= 12'hfd8 && t <= 12'hfef && t[2:0] != 3'h0) return;
        re0 = n_re;
        we0 = n_we;
        core(wr, ab, f, w, d, b);
        cmp_addr(mem_addr, t);
        cmp_word(32'((n_re - re0) * 2 + n_we - we0), wr ? 32'h1 : 32'h2);
        if (wr) begin
            shadow[t] = d;
        end else begin
            cmp_byte(acc_rdata, shadow[t]);
        end
        if (e >= 12'hfd8 && e <= 12'hfef && e[2:0] inside {3'h4, 3'h6}) begin
            ptr[p] = ptr[p] + 12'h1;
        end
        if (e >= 12'hfd8 && e <= 12'hfef && e[2:0] == 3'h5) begin
            ptr[p] = ptr[p] - 12'h1;
        end
        chk_ptrs();
    endtask
    // Main sequence
    initial begin
        logic [7:0] f;
        logic [3:0] b;
        logic [11:0] corner [4];
        int p, we0;
        corner = '{12'h000, 12'h0ff, 12'h100, 12'hfff};
        {hresetn, hsel, hwrite, acc_valid, xset} = 5'h0;
        {haddr, hwdata, htrans, bank_sel} = '0;
        acc_req = '0;
        ce = 1'b1;
        hsize = 3'h2;
        for (int i = 0; i < 4096; i++) begin
            shadow[i] = 8'(i) ^ 8'(i >> 4);
        end
        ptr = '{12'h000, 12'h000, 12'h000};
        void'($urandom(32'h67e3));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        hsel <= 1'b1;
        // Reset values, unmapped places and ignored writes
        bus(1'b1, 32'h14, 32'hffffffff);
        for (int a = 0; a < 7; a++) begin
            bus(1'b0, (a == 6) ? 32'h104 : 32'(a * 4), 32'h0);
            cmp_word(rd, 32'h0);
        end
        // Random accesses with corner pointer values
        for (int i = 0; i < 240; i++) begin
            if (i % 8 == 0) begin
                xset = 1'($urandom);
                bus(1'b1, 32'h0c, {31'h0, xset});
                for (int q = 0; q < 3; q++) begin
                    set_ptr(q, (i % 16 == 0) ? corner[$urandom % 4] : 12'($urandom));
                end
            end
            b = 4'($urandom);
            f = 8'($urandom);
            p = $urandom % 3;
            if (i % 3 == 0) begin
                f = ((p == 2) ? 8'hd8 : (p == 1) ? 8'he0 : 8'he8) | 8'(3 + $urandom % 5);
                step(1'($urandom), 1'b0, f, b);
            end else begin
                if ((p == 0 || b == 4'hf) && f >= 8'hd8 && f <= 8'hef) f = f ^ 8'h20;
                step(1'($urandom), p != 0, f, b);
            end
        end
        // Indirect access to another register in the operand window
        bus(1'b1, 32'h0c, 32'h0);
        xset = 1'b0;
        set_ptr(0, 12'hfd8);
        step(1'b0, 1'b0, 8'hef, 4'h3);
        // Pointer aimed at a virtual operand of another pair
        set_ptr(0, 12'hfe7);
        set_ptr(1, 12'h123);
        we0 = n_re + n_we;
        core(1'b0, 1'b0, 8'hef, 8'h00, 8'h00, 4'h0);
        cmp_byte(acc_rdata, 8'h00);
        bus(1'b0, 32'h10, 32'h0);
        cmp_byte({7'h0, rd[16]}, 8'h01);
        core(1'b1, 1'b0, 8'hef, 8'h00, 8'h55, 4'h0);
        cmp_word(32'(n_re + n_we - we0), 32'h0);
        chk_ptrs();
        // Own pointer written through its own operand
        set_ptr(2, 12'hfd9);
        core(1'b1, 1'b0, 8'hdd, 8'h00, 8'h34, 4'h0);
        ptr[2] = 12'hf34;
        chk_ptrs();
        // Pointer bytes reached by direct access
        core(1'b1, 1'b0, 8'hda, 8'h00, 8'hab, 4'h0);
        ptr[2] = 12'hb34;
        chk_ptrs();
        core(1'b0, 1'b0, 8'hd9, 8'h00, 8'h00, 4'h0);
        cmp_byte(acc_rdata, 8'h34);
        core(1'b0, 1'b0, 8'hda, 8'h00, 8'h00, 4'h0);
        cmp_byte(acc_rdata, 8'h0b);
        cmp_word(32'(n_re + n_we - we0), 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire

// file: sim/iag_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module iag_mem_model (
    // Clock
    input wire logic hclk,
    // Memory port driven by the generator
    input wire logic [11:0] mem_addr,
    input wire logic mem_re,
    input wire logic mem_we,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [4096]; // Whole linear data space
    logic [7:0] last_q = 8'h00; // Last byte given out
    // Known start pattern so reads can be predicted
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'(i) ^ 8'(i >> 4);
        end
    end
    // Stores and last-value tracking
    always @(posedge hclk) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
        if (mem_re) begin
            last_q <= mem[mem_addr];
        end
    end
    // Data only while selected, otherwise a changing junk value
    assign mem_rdata = mem_re ? mem[mem_addr] : ~last_q;
endmodule
`default_nettype wire
